// ### pkg/timer_defs.svh
// Overview of operation
// [RULE1] Sixteen-bit up-counter; all-ones wraps to zero and counting continues.
// [RULE2] System clock divided by prescale 1 to 128 in clock-driven modes.
// [RULE3] Reload zero gives longest time-out; reload one, prescale one, the shortest.
// [RULE4] Reload one with prescale one is the minimum time-out setting.
// [RULE5] External input transitions stay at or below a quarter of system clock.
// [RULE6] One-shot, continuous and PWM modes count prescaled system clock only.
// [RULE7] One-shot: at reload, interrupt, count to one, clear enable, stop.
// [RULE8] One-shot: output inverted for exactly one clock at reload when enabled.
// [RULE9] Software sets polarity, starts, then flips polarity for lasting change.
// [RULE10] Continuous: at reload, interrupt, count to one, continue, toggle output.
// [RULE11] Written start count applies to first pass only; later passes start at one.
// [RULE12] Counter mode counts external input transitions, not system clock.
// [RULE13] Counter mode edge chosen by polarity bit; prescaler bypassed.
// [RULE14] Counter mode polarity also sets initial output level.
// [RULE15] Counter: at reload, interrupt, count to one, continue, toggle output.
// [RULE16] Software loads start count one before enabling counter mode.
// [RULE17] PWM: toggle output at PWM match, keep counting to reload.
// [RULE18] PWM: at reload, interrupt, count to one, resume counting.
// [RULE19] PWM polarity one: start high, low at match, high at reload.
// [RULE20] PWM polarity zero: start low, high at match, low at reload.
// [RULE21] Software keeps PWM reload strictly above PWM match value.
// [RULE22] Software disables, configures, loads values, then enables the timer.
// [RULE23] External input synchronised; edge found from consecutive samples as one pulse.
// [RULE24] Pin driven from internal state bit only while output function enabled.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define TMR_COUNT_RESET    16'h0000
`define TMR_COUNT_ONE      16'h0001
`define TMR_RELOAD_RESET   16'h0000
`define TMR_PRESCALE_MAX   8'h80
`define TMR_PRESCALE_LOG_W 3
`endif

// ### pkg/timer_pkg.sv
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_ONE_SHOT,
    MODE_CONTINUOUS,
    MODE_COUNTER,
    MODE_PWM
  } timer_mode_t;
endpackage

// ### rtl/timer_edge_detect.sv
`timescale 1ns/10ps
module timer_edge_detect (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic sig_i,
  input  wire logic rising_sel_i,
  output logic      edge_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edge_hit;
  } edge_state_t;

  edge_state_t st_r;
  edge_state_t st_nxt;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sync1    = sig_i;
    st_nxt.sync2    = st_r.sync1;
    st_nxt.prev     = st_r.sync2;
    st_nxt.edge_hit = rising_sel_i ? (st_r.sync2 & ~st_r.prev)
                                   : (~st_r.sync2 & st_r.prev); // RULE23
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_o = st_r.edge_hit;
endmodule // timer_edge_detect

// ### rtl/reloadable_timer.sv
`timescale 1ns/10ps
`include "timer_defs.svh"
module reloadable_timer
  import timer_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               enable_i,
  output logic                    enable_o,
  input  wire timer_mode_t        mode_i,
  input  wire logic [2:0]         prescale_sel_i,
  input  wire logic               input_output_polarity_select_i,
  input  wire logic               count_wr_i,
  input  wire logic [COUNT_W-1:0] count_wdata_i,
  input  wire logic [COUNT_W-1:0] reload_i,
  input  wire logic [COUNT_W-1:0] pwm_value_i,
  input  wire logic               out_func_en_i,
  input  wire logic               timer_in_i,
  output logic [COUNT_W-1:0]      count_o,
  output logic                    irq_o,
  output logic                    timer_out_o,
  output logic                    timer_out_oe_o
);
  typedef struct packed {
    logic               run;
    logic               run_prev;
    logic [7:0]         prescale_cnt;
    logic [COUNT_W-1:0] count;
    logic               out_state;
    logic               pulse;
    logic               irq;
    logic               pin;
    logic               pin_oe;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;
  logic         in_edge;
  logic [7:0]   prescale_div;
  logic         tick;
  logic         at_reload;
  logic         start;

  timer_edge_detect u_edge (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .sig_i        (timer_in_i),
    .rising_sel_i (input_output_polarity_select_i),
    .edge_o       (in_edge)
  ); // RULE13

  function automatic logic [7:0] prescale_decode(input logic [2:0] sel);
    prescale_decode = 8'h01 << sel;
  endfunction

  always_comb begin
    prescale_div = prescale_decode(prescale_sel_i); // RULE2
    start        = enable_i & ~st_r.run_prev;
    if (mode_i == MODE_COUNTER) begin
      tick = st_r.run & in_edge; // RULE12 RULE13
    end else begin
      tick = st_r.run & (st_r.prescale_cnt == prescale_div - 8'h01); // RULE6
    end
    at_reload = (st_r.count == reload_i); // RULE3 RULE4
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.irq      = 1'b0;
    st_nxt.pulse    = 1'b0;
    st_nxt.run_prev = enable_i;
    if (!enable_i) begin
      st_nxt.run = 1'b0;
    end else if (start) begin
      st_nxt.run = 1'b1;
    end
    if (!st_r.run || mode_i == MODE_COUNTER) begin
      st_nxt.prescale_cnt = 8'h00;
    end else if (tick) begin
      st_nxt.prescale_cnt = 8'h00;
    end else begin
      st_nxt.prescale_cnt = st_r.prescale_cnt + 8'h01;
    end
    if (!st_r.run && !enable_i) begin
      st_nxt.out_state = (mode_i == MODE_COUNTER || mode_i == MODE_PWM)
                         ? input_output_polarity_select_i : st_r.out_state; // RULE14 RULE19
      if (mode_i == MODE_ONE_SHOT || mode_i == MODE_CONTINUOUS) begin
        st_nxt.out_state = input_output_polarity_select_i;
      end
    end else if (!st_r.run && mode_i == MODE_ONE_SHOT) begin
      st_nxt.out_state = input_output_polarity_select_i; // RULE9
    end
    if (count_wr_i) begin
      st_nxt.count = count_wdata_i; // RULE11
    end else if (tick) begin
      if (at_reload) begin
        st_nxt.count = COUNT_W'(`TMR_COUNT_ONE); // RULE11
        st_nxt.irq   = 1'b1;
        case (mode_i)
          MODE_ONE_SHOT: begin
            st_nxt.run   = 1'b0; // RULE7
            st_nxt.pulse = 1'b1; // RULE8
          end
          MODE_CONTINUOUS: st_nxt.out_state = ~st_r.out_state; // RULE10
          MODE_COUNTER:    st_nxt.out_state = ~st_r.out_state; // RULE15
          MODE_PWM:        st_nxt.out_state = input_output_polarity_select_i; // RULE18 RULE19 RULE20
          default:         st_nxt.out_state = st_r.out_state;
        endcase
      end else begin
        st_nxt.count = st_r.count + COUNT_W'(`TMR_COUNT_ONE); // RULE1
        if (mode_i == MODE_PWM && st_r.count == pwm_value_i) begin
          st_nxt.out_state = ~input_output_polarity_select_i; // RULE17 RULE20
        end
      end
    end
    // Pulse only rises in one-shot; gating here keeps the pin a plain flop
    st_nxt.pin    = (st_nxt.out_state ^ st_nxt.pulse) & out_func_en_i; // RULE8 RULE24
    st_nxt.pin_oe = out_func_en_i; // RULE24
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.count <= `TMR_COUNT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign enable_o       = st_r.run;
  assign count_o        = st_r.count;
  assign irq_o          = st_r.irq;
  assign timer_out_o    = st_r.pin; // RULE24
  assign timer_out_oe_o = st_r.pin_oe;
endmodule // reloadable_timer

// ### tb/timer_in_model.sv
`timescale 1ns/10ps
module timer_in_model (
  input  wire logic clk_sys_i,
  input  wire logic run_i,
  output logic      pin_o
);
  int cnt = 0;
  initial pin_o = 1'b0;
  // Edges eight clocks apart, still while idle
  always @(negedge clk_sys_i) begin
    if (run_i) begin
      cnt <= (cnt == 7) ? 0 : cnt + 1;
      if (cnt == 7) pin_o <= ~pin_o;
    end
  end
endmodule // timer_in_model

// ### tb/timer_monitor.sv
`timescale 1ns/10ps
module timer_monitor
  import timer_pkg::*;
#(parameter int COUNT_W = 16) (
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire logic               enable_o,
  input wire timer_mode_t        mode_i,
  input wire logic [2:0]         prescale_sel_i,
  input wire logic               input_output_polarity_select_i,
  input wire logic               count_wr_i,
  input wire logic [COUNT_W-1:0] count_wdata_i,
  input wire logic [COUNT_W-1:0] reload_i,
  input wire logic               irq_o,
  input wire logic [COUNT_W-1:0] count_o,
  input wire logic               timer_out_o,
  input wire logic               timer_out_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  irq_count_one_a: assert property (irq_o |-> count_o == 1)
    else $error("count not one at irq");
  irq_cause_a: assert property (irq_o |-> $past(count_o) == $past(reload_i))
    else $error("irq without reload match");
  oneshot_stop_a: assert property (
    irq_o && mode_i == MODE_ONE_SHOT |-> ##[0:1] !enable_o) else $error("one-shot kept running");
  count_load_a: assert property (
    count_wr_i |=> count_o == $past(count_wdata_i)) else $error("count load lost");
  prescale_gap_a: assert property (
    $changed(count_o) && enable_o && prescale_sel_i == 3'h3 && mode_i != MODE_COUNTER
    |=> $stable(count_o) [*7]) else $error("prescale eight broken");
  pwm_reload_a: assert property (
    irq_o && mode_i == MODE_PWM && timer_out_oe_o |-> timer_out_o == input_output_polarity_select_i)
    else $error("pwm level at reload");
  oneshot_pulse_a: assert property (
    irq_o && mode_i == MODE_ONE_SHOT && timer_out_oe_o
    |-> timer_out_o != $past(timer_out_o)
    ##1 timer_out_o == input_output_polarity_select_i) else $error("one-shot pulse width");
  pin_release_a: assert property (!timer_out_oe_o |-> !timer_out_o)
    else $error("pin driven while released");
endmodule // timer_monitor
bind reloadable_timer timer_monitor #(.COUNT_W(COUNT_W)) mon (.*);

// ### tb/reloadable_timer_tb_top.sv
`timescale 1ns/10ps
module reloadable_timer_tb_top
  import timer_pkg::*;
;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, en = 1'b0, pol = 1'b0, wr = 1'b0, oen = 1'b0;
  logic        eo, irq, tout, toe, tin, t, prun = 1'b0;
  timer_mode_t mode = MODE_ONE_SHOT;
  logic [2:0]  psel = 3'h0;
  logic [15:0] wd = 16'h0000, rl = 16'h0000, pv = 16'h0003, cnt;
  int          error_cnt = 0, n_tests = 0, cyc = 0, n;
  reloadable_timer DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(en), .enable_o(eo),
    .mode_i(mode), .prescale_sel_i(psel), .input_output_polarity_select_i(pol),
    .count_wr_i(wr), .count_wdata_i(wd), .reload_i(rl), .pwm_value_i(pv),
    .out_func_en_i(oen), .timer_in_i(tin), .count_o(cnt), .irq_o(irq),
    .timer_out_o(tout), .timer_out_oe_o(toe));
  timer_in_model PIN (.clk_sys_i(clk_sys_i), .run_i(prun), .pin_o(tin));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string w, input logic [16:0] e, s);
    n_tests++;
    if (e !== s) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", w, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic go(input timer_mode_t m, input logic [2:0] ps, input logic p,
                    input logic [15:0] s, r);
    en = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    mode = m;
    psel = ps;
    pol = p;
    wd = s;
    rl = r;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
    en = 1'b1;
  endtask
  task automatic wirq();
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (irq !== 1'b1);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("count", 17'h0, {1'b0, cnt});
    oen = 1'b1;
    go(MODE_CONTINUOUS, 3'h0, 1'b0, 16'h0001, 16'h0005);
    wirq();
    t = tout;
    wirq();
    chk("gap", 17'h5, n);
    chk("pin", {16'h0000, ~t}, {16'h0000, tout});
    go(MODE_CONTINUOUS, 3'h3, 1'b0, 16'h0001, 16'h0002);
    wirq();
    wirq();
    chk("gap", 17'h10, n);
    go(MODE_CONTINUOUS, 3'h0, 1'b0, 16'h0001, 16'h0001);
    wirq();
    wirq();
    chk("gap", 17'h1, n);
    go(MODE_CONTINUOUS, 3'h0, 1'b0, 16'hFFF0, 16'h0000);
    wirq();
    wirq();
    chk("gap", 17'h10000, n);
    $display("periodic tests done");
    go(MODE_ONE_SHOT, 3'h0, 1'b1, 16'h0001, 16'h0003);
    wirq();
    repeat (4) @(negedge clk_sys_i);
    chk("run", 17'h0, 17'(eo));
    chk("count", 17'h1, {1'b0, cnt});
    chk("pin", 17'h1, {16'h0000, tout});
    go(MODE_ONE_SHOT, 3'h0, 1'b0, 16'h0001, 16'h0003);
    repeat (2) @(negedge clk_sys_i);
    pol = 1'b1;
    wirq();
    repeat (4) @(negedge clk_sys_i);
    chk("lasting", 17'h1, {16'h0000, tout});
    $display("one-shot test done");
    prun = 1'b1;
    go(MODE_COUNTER, 3'h0, 1'b1, 16'h0001, 16'h0003);
    chk("level", 17'h1, 17'(tout));
    wirq();
    wirq();
    chk("gap", 17'h30, n);
    prun = 1'b0;
    $display("counter test done");
    for (int p = 0; p < 2; p++) begin
      go(MODE_PWM, 3'h0, p[0], 16'h0001, 16'h0006);
      wirq();
      wirq();
      chk("gap", 17'h6, n);
      repeat (4) @(negedge clk_sys_i);
      chk("pwm", {16'h0000, ~p[0]}, {16'h0000, tout});
    end
    $display("pwm tests done");
    test_done();
  end
endmodule // reloadable_timer_tb_top
